// File: rtl/irq_wdt_regs.svh
// Register offsets, field positions, reset values and timing counts
// Functional notes
// [RULE1] Power button flags on press, optionally release; debounced level readable. The level register returns the two-stage synchronised level, not debounced.
// [RULE2] Second button flags on press, optionally release; debounced level readable. The level register returns the two-stage synchronised level, not debounced.
// [RULE3] Over-temperature-high flag when die exceeds upper threshold.
// [RULE4] Over-temperature-low flag when die falls from above high to below low.
// [RULE5] Charger detect, overvoltage, watchdog, bus-valid, battery-absent sources.
// [RULE6] Bus-valid and battery-absent are level sources with 0/100/200/400us debounce.
// [RULE7] High-battery flag when measured voltage exceeds programmed upper threshold.
// [RULE8] Low-battery flag when measured voltage falls below programmed lower threshold.
// [RULE9] Speaker class-D and class-AB over-current are level sources.
// [RULE10] Each buck has its own over-current level source.
// [RULE11] One linear regulator over-current source, debounce 100/200/400/800us.
// [RULE12] Status bits clear on writing one; zero leaves them.
// [RULE13] Watchdog timeout selectable among 4, 8, 16, 32 s.
// [RULE14] Watchdog starts counting when charger enable is set.
// [RULE15] Kick register write before timeout, else timeout flagged.
// [RULE16] Charging only with charger present, enable set, no timeout.
// [RULE17] Interrupt output high while any enabled status bit pending.
// [RULE18] Edge sources set on qualifying edge; level sources while active.
`ifndef IRQ_WDT_REGS_SVH
`define IRQ_WDT_REGS_SVH
// ==========================================================
// Register indices; byte address is four times the index
`define IDX_EN_A      12'h160
`define IDX_EN_B      12'h166
`define IDX_ST_A      12'h172
`define IDX_ST_B      12'h174
`define IDX_CTRL      12'h180
`define IDX_KICK      12'h181
`define IDX_BATTH     12'h182
`define IDX_LEVEL     12'h183
// ==========================================================
// Group A bit positions
`define A_SPK_AB      0
`define A_SPK_D       1
`define A_BAT_L       2
`define A_BAT_H       3
`define A_WDOG        4
`define A_POWER_BUTTON      5
`define A_OVER_TEMP_LOW       6
`define A_OVER_TEMP_HIGH       7
`define A_BATABS      8
`define A_BVALID      9
`define A_CHARGER_PRESENT      10
`define A_OV          11
// Group B bit positions
`define B_LDO         0
`define B_KEY2        1
`define B_ACC         2
`define B_AUDIO       3
`define B_RTC         4
`define B_CORE        5
`define B_SYS         6
`define B_PA          7
// Control register fields
`define C_CHG_EN      0
`define C_GEAR_LO     1
`define C_PWR_REL     3
`define C_KEY2_REL    4
`define C_BV_DEB_LO   5
`define C_LDO_DEB_LO  7
// ==========================================================
// Reset values
`define EN_A_RST      16'h0000
`define EN_B_RST      16'h0000
`define CTRL_RST      16'h0000
// ==========================================================
// Timing, clock 10 MHz
`define CLK_HZ        10000000
`define OV_DEB_US     4
`define OV_DEB_CYC    ((`OV_DEB_US * `CLK_HZ) / 1000000)
`define DEB_100_US    100
`define DEB_100_CYC   ((`DEB_100_US * `CLK_HZ) / 1000000)
`define WDT_BASE_S    4
`endif

// File: rtl/irq_wdt_pkg.sv
// Types shared by the interrupt and watchdog block
package irq_wdt_pkg;
  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
  } bat_thresh_t;
  typedef enum logic [1:0] {
    WD_IDLE  = 2'b00,
    WD_COUNT = 2'b01,
    WD_TOUT  = 2'b11
  } wd_state_t;
endpackage

// File: rtl/pmic_irq_wdt.sv
// Interrupt collector and charging watchdog with APB register access
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_wdt_regs.svh"
module pmic_irq_wdt
  import irq_wdt_pkg::*;
#(
  parameter int unsigned WDT_BASE_CYC = `WDT_BASE_S * `CLK_HZ
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        power_button,
  input  wire logic        second_button,
  input  wire logic        over_temp_high,
  input  wire logic        charger_present,
  input  wire logic        charger_overvoltage,
  input  wire logic        bus_valid_detect,
  input  wire logic        battery_absent_detect,
  input  wire logic [14:0] battery_voltage,
  input  wire logic        speaker_d_overcurrent,
  input  wire logic        speaker_ab_overcurrent,
  input  wire logic        pa_buck_overcurrent,
  input  wire logic        system_buck_overcurrent,
  input  wire logic        core_buck_overcurrent,
  input  wire logic        linear_reg_overcurrent,
  input  wire logic        rtc_alarm_n,
  input  wire logic        audio_event,
  input  wire logic        accessory_event,
  output logic             charge_allow,
  output logic             irq
);
  localparam int NRAW = 17;
  localparam logic [15:0] OV_CYC  = 16'(`OV_DEB_CYC);
  localparam logic [15:0] D100    = 16'(`DEB_100_CYC);

  // ==========================================================
  // Pin synchronisers
  logic [NRAW-1:0] raw_in, sync1_r, sync2_r;
  assign raw_in = {accessory_event, audio_event, ~rtc_alarm_n,
                   linear_reg_overcurrent, core_buck_overcurrent,
                   system_buck_overcurrent, pa_buck_overcurrent,
                   speaker_ab_overcurrent, speaker_d_overcurrent,
                   battery_absent_detect, bus_valid_detect,
                   charger_overvoltage, charger_present, over_temp_high,
                   second_button, power_button, 1'b0};
  // Two stages; only the second stage is read by logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end
  logic [14:0] vbat1_r, vbat2_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vbat1_r <= '0;
      vbat2_r <= '0;
    end else begin
      vbat1_r <= battery_voltage;
      vbat2_r <= vbat1_r;
    end
  end

  // ==========================================================
  // Registers
  logic [15:0] en_a_r, en_b_r, st_a_r, st_b_r, ctrl_r;
  bat_thresh_t thr_r;
  logic        wr_en, rd_en;
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] i);
    hit = (a == 12'(i << 2));
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `IDX_EN_A) | hit(a, `IDX_EN_B) | hit(a, `IDX_ST_A) |
             hit(a, `IDX_ST_B) | hit(a, `IDX_CTRL) | hit(a, `IDX_KICK) |
             hit(a, `IDX_BATTH) | hit(a, `IDX_LEVEL);
  endfunction

  assign pslverr = psel & penable & ~mapped(paddr);

  // Software-written configuration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_a_r <= `EN_A_RST;
      en_b_r <= `EN_B_RST;
      ctrl_r <= `CTRL_RST;
      thr_r  <= '{lo: 16'h0000, hi: 16'h7fff};
    end else if (wr_en) begin
      if (hit(paddr, `IDX_EN_A))  en_a_r <= pwdata[15:0] & 16'h0fff;
      if (hit(paddr, `IDX_EN_B))  en_b_r <= pwdata[15:0] & 16'h00ff;
      if (hit(paddr, `IDX_CTRL))  ctrl_r <= pwdata[15:0] & 16'h01ff;
      if (hit(paddr, `IDX_BATTH)) thr_r  <= pwdata;
    end
  end

  // ==========================================================
  // Debounce and event detection
  logic [1:0]  gear;
  logic [1:0]  bv_sel, ldo_sel;
  assign gear    = ctrl_r[`C_GEAR_LO +: 2];
  assign bv_sel  = ctrl_r[`C_BV_DEB_LO +: 2];
  assign ldo_sel = ctrl_r[`C_LDO_DEB_LO +: 2];

  // Delays 0/100/200/400us for level charger sources [RULE6]
  logic [15:0] bv_lim, ldo_lim;
  assign bv_lim  = (bv_sel == 2'd0) ? 16'h0000 :
                   16'(D100 << (bv_sel - 2'd1));                 // [RULE6]
  assign ldo_lim = 16'(D100 << ldo_sel);                          // [RULE11]

  // Counter filters: output follows input once stable for limit cycles
  logic [15:0] cnt_r [4];
  logic [3:0]  deb_r;
  logic [3:0]  deb_in;
  logic [15:0] deb_lim [4];
  // Overvoltage, bus-valid, battery-absent, linear regulator
  assign deb_in = {sync2_r[13], sync2_r[7], sync2_r[6], sync2_r[5]};
  assign deb_lim[0] = OV_CYC;                                     // [RULE5]
  assign deb_lim[1] = bv_lim;
  assign deb_lim[2] = bv_lim;
  assign deb_lim[3] = ldo_lim;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_deb
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          cnt_r[g] <= '0;
          deb_r[g] <= 1'b0;
        end else if (deb_in[g] == deb_r[g]) begin
          cnt_r[g] <= '0;
        end else if (cnt_r[g] + 16'd1 >= deb_lim[g]) begin
          cnt_r[g] <= '0;
          deb_r[g] <= deb_in[g];
        end else begin
          cnt_r[g] <= cnt_r[g] + 16'd1;
        end
      end
    end
  endgenerate

  // Previous values for edge detection and thermal hysteresis
  logic pwr_q_r, key2_q_r, chr_q_r, ov_q_r, hot_q_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_q_r  <= 1'b0;
      key2_q_r <= 1'b0;
      chr_q_r  <= 1'b0;
      ov_q_r   <= 1'b0;
      hot_q_r  <= 1'b0;
    end else begin
      pwr_q_r  <= sync2_r[1];
      key2_q_r <= sync2_r[2];
      chr_q_r  <= sync2_r[4];
      ov_q_r   <= deb_r[0];
      hot_q_r  <= sync2_r[3];
    end
  end

  // ==========================================================
  // Watchdog
  wd_state_t   wd_state_r;
  logic [31:0] wd_cnt_r, wd_lim;
  logic        kick, wd_expire;
  assign kick      = wr_en & hit(paddr, `IDX_KICK);
  assign wd_lim    = 32'(WDT_BASE_CYC) << gear;                   // [RULE13]
  assign wd_expire = (wd_state_r == WD_COUNT) &&
                     (wd_cnt_r + 32'd1 >= wd_lim);
  // Counting only while charging is enabled; kick restarts the count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wd_state_r <= WD_IDLE;
      wd_cnt_r   <= '0;
    end else begin
      case (wd_state_r)
        WD_IDLE: begin
          wd_cnt_r <= '0;
          if (ctrl_r[`C_CHG_EN]) wd_state_r <= WD_COUNT;       // [RULE14]
        end
        WD_COUNT: begin
          if (!ctrl_r[`C_CHG_EN]) begin
            wd_state_r <= WD_IDLE;
          end else if (kick) begin
            wd_cnt_r <= '0;                                     // [RULE15]
          end else if (wd_expire) begin
            wd_state_r <= WD_TOUT;                              // [RULE15]
          end else begin
            wd_cnt_r <= wd_cnt_r + 32'd1;
          end
        end
        WD_TOUT: begin
          // Timeout holds until charging is disabled by software
          wd_cnt_r <= '0;
          if (!ctrl_r[`C_CHG_EN]) wd_state_r <= WD_IDLE;
        end
        default: wd_state_r <= WD_IDLE;
      endcase
    end
  end

  // Charging gate [RULE16]
  always_ff @(posedge clk) begin
    if (!rst_n) charge_allow <= 1'b0;
    else charge_allow <= sync2_r[4] & ctrl_r[`C_CHG_EN] &
                         (wd_state_r != WD_TOUT);                 // [RULE16]
  end

  // ==========================================================
  // Event vectors
  logic [15:0] set_a, set_b, clr_a, clr_b;
  logic        vb_hi, vb_lo;
  assign vb_hi = {1'b0, vbat2_r} > thr_r.hi;                      // [RULE7]
  assign vb_lo = {1'b0, vbat2_r} < thr_r.lo;                      // [RULE8]
  always_comb begin
    set_a = '0;
    set_a[`A_POWER_BUTTON] = (sync2_r[1] & ~pwr_q_r) |
                       (ctrl_r[`C_PWR_REL] & ~sync2_r[1] & pwr_q_r); // [RULE1]
    set_a[`A_OVER_TEMP_HIGH]  = sync2_r[3] & ~hot_q_r;                     // [RULE3]
    set_a[`A_OVER_TEMP_LOW]  = ~sync2_r[3] & hot_q_r;                     // [RULE4]
    set_a[`A_CHARGER_PRESENT] = sync2_r[4] ^ chr_q_r;                      // [RULE5]
    set_a[`A_OV]     = deb_r[0] & ~ov_q_r;                        // [RULE18]
    set_a[`A_BVALID] = deb_r[1];                                  // [RULE18]
    set_a[`A_BATABS] = deb_r[2];                                  // [RULE6]
    set_a[`A_WDOG]   = (wd_state_r == WD_TOUT);                   // [RULE5]
    set_a[`A_BAT_H]  = vb_hi;
    set_a[`A_BAT_L]  = vb_lo;
    set_a[`A_SPK_D]  = sync2_r[8];                                // [RULE9]
    set_a[`A_SPK_AB] = sync2_r[9];                                // [RULE9]
    set_b = '0;
    set_b[`B_KEY2]   = (sync2_r[2] & ~key2_q_r) |
                       (ctrl_r[`C_KEY2_REL] & ~sync2_r[2] & key2_q_r); // [RULE2]
    set_b[`B_PA]     = sync2_r[10];                               // [RULE10]
    set_b[`B_SYS]    = sync2_r[11];                               // [RULE10]
    set_b[`B_CORE]   = sync2_r[12];                               // [RULE10]
    set_b[`B_LDO]    = deb_r[3];                                  // [RULE11]
    set_b[`B_RTC]    = sync2_r[14];
    set_b[`B_AUDIO]  = sync2_r[15];
    set_b[`B_ACC]    = sync2_r[16];
  end
  assign clr_a = (wr_en && hit(paddr, `IDX_ST_A)) ? pwdata[15:0] : 16'h0000;
  assign clr_b = (wr_en && hit(paddr, `IDX_ST_B)) ? pwdata[15:0] : 16'h0000;

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_a_r <= '0;
      st_b_r <= '0;
    end else begin
      st_a_r <= (st_a_r & ~clr_a) | set_a;                        // [RULE12]
      st_b_r <= (st_b_r & ~clr_b) | set_b;                        // [RULE12]
    end
  end

  // Interrupt line from enabled pending bits
  always_ff @(posedge clk) begin
    if (!rst_n) irq <= 1'b0;
    else irq <= |(st_a_r & en_a_r) | |(st_b_r & en_b_r);          // [RULE17]
  end

  // ==========================================================
  // Read data, registered in setup phase for the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (hit(paddr, `IDX_EN_A))  prdata <= {16'h0000, en_a_r};
      if (hit(paddr, `IDX_EN_B))  prdata <= {16'h0000, en_b_r};
      if (hit(paddr, `IDX_ST_A))  prdata <= {16'h0000, st_a_r};
      if (hit(paddr, `IDX_ST_B))  prdata <= {16'h0000, st_b_r};
      if (hit(paddr, `IDX_CTRL))  prdata <= {16'h0000, ctrl_r};
      if (hit(paddr, `IDX_BATTH)) prdata <= thr_r;
      if (hit(paddr, `IDX_LEVEL))
        prdata <= {27'h0, wd_state_r, charge_allow,
                   sync2_r[2], sync2_r[1]};                       // [RULE1] [RULE2]
    end
  end
  logic unused;
  assign unused = rd_en | sync2_r[0];
endmodule
`default_nettype wire

// File: verif/irq_wdt_checker_assertions.sv
// Port-level checker for the interrupt collector and charge watchdog
`timescale 1ns/1ps
`default_nettype none
`include "irq_wdt_regs.svh"
module irq_wdt_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        charger_present,
  input wire logic        charge_allow,
  input wire logic        irq
);
  // ========
  // Access phase and address decode
  logic acc;
  logic mapped;
  assign acc = psel && penable;
  assign mapped = paddr inside {`IDX_EN_A*4, `IDX_EN_B*4, `IDX_ST_A*4,
    `IDX_ST_B*4, `IDX_CTRL*4, `IDX_KICK*4, `IDX_BATTH*4, `IDX_LEVEL*4};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ========
  // Bus answer, refusal and read width
  a_ready_always: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (
    acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access phase");
  a_upper_zero: assert property (
    acc && !pwrite && mapped && paddr != `IDX_BATTH*4
    |-> prdata[31:16] == 16'h0000)
    else $error("upper half of narrow register not zero");
  // ========
  // Outputs after reset and charge gating
  a_out_reset: assert property (
    $rose(rst_n) |-> !irq && !charge_allow)
    else $error("output high just after reset");
  a_allow_needs_chg: assert property (
    !charger_present [*5] |-> !charge_allow)
    else $error("charging allowed without charger");
  a_allow_off_dis: assert property (
    acc && pwrite && paddr == `IDX_CTRL*4 && !pwdata[0]
    |-> ##[1:3] !charge_allow)
    else $error("charging kept after enable cleared");
endmodule
bind pmic_irq_wdt irq_wdt_checker u_irq_wdt_checker (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .charger_present(charger_present),
  .charge_allow(charge_allow), .irq(irq));
`default_nettype wire

// File: verif/host_model.sv
// Host processor model: APB master servicing the block's registers
`timescale 1ns/1ps
`default_nettype none
`include "irq_wdt_regs.svh"
module host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // ========
  // Idle bus from time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // One transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Status bits are dropped only by writing ones
  task automatic clear(input logic [11:0] a, input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, m, r, e);
  endtask
  // Kick the watchdog; any data restarts the count
  task automatic kick();
    logic [31:0] r;
    logic        e;
    xfer(1'b1, 12'(`IDX_KICK*4), 32'h0, r, e);
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the interrupt collector and charge watchdog
`timescale 1ns/1ps
`default_nettype none
`include "irq_wdt_regs.svh"
module tb import irq_wdt_pkg::*;;
  // ========
  // Short watchdog base keeps the run small
  localparam int          BASE  = 100;
  localparam logic [11:0] A_ENA = 12'(`IDX_EN_A*4);
  localparam logic [11:0] A_ENB = 12'(`IDX_EN_B*4);
  localparam logic [11:0] A_STA = 12'(`IDX_ST_A*4);
  localparam logic [11:0] A_STB = 12'(`IDX_ST_B*4);
  localparam logic [11:0] A_CTL = 12'(`IDX_CTRL*4);
  localparam logic [11:0] A_BTH = 12'(`IDX_BATTH*4);
  localparam logic [11:0] A_LVL = 12'(`IDX_LEVEL*4);
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        irq, chg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] pin;
  logic [14:0] bv;
  int          n_mismatch, total_checks;
  // Source table: pin, group, status bit
  logic [11:0] tab [15] = '{12'h800, 12'h701, 12'h509, 12'h608,
    12'h40b, 12'h005, 12'h30a, 12'h917, 12'ha16, 12'hb15, 12'hf12,
    12'he13, 12'hd14, 12'h111, 12'hc10};
  pmic_irq_wdt #(.WDT_BASE_CYC(BASE)) u_pmic_irq_wdt (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .power_button(pin[0]),
    .second_button(pin[1]), .over_temp_high(pin[2]),
    .charger_present(pin[3]), .charger_overvoltage(pin[4]),
    .bus_valid_detect(pin[5]), .battery_absent_detect(pin[6]),
    .battery_voltage(bv), .speaker_d_overcurrent(pin[7]),
    .speaker_ab_overcurrent(pin[8]), .pa_buck_overcurrent(pin[9]),
    .system_buck_overcurrent(pin[10]),
    .core_buck_overcurrent(pin[11]),
    .linear_reg_overcurrent(pin[12]), .rtc_alarm_n(pin[13]),
    .audio_event(pin[14]), .accessory_event(pin[15]),
    .charge_allow(chg), .irq(irq));
  host_model u_host_model (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ========
  // Compare, bus and pin helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] x);
    total_checks++;
    if (seen !== x) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, x);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_host_model.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    u_host_model.xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic flip(input logic [15:0] m);
    @(posedge clk);
    pin <= pin ^ m;
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    results();
  end
  // ========
  // Main sequence
  initial begin
    int          p;
    int          b;
    int          m;
    logic [11:0] sa;
    logic [31:0] r;
    logic        e;
    void'($urandom(77));
    rst_n = 1'b0;
    pin = 16'h2000;
    bv = 15'h3000;
    tick(5);
    rst_n <= 1'b1;
    rdc(A_ENA, 32'h0);
    rdc(A_CTL, 32'h0);
    rdc(A_BTH, 32'h00007fff);
    u_host_model.xfer(1'b0, 12'h7fc, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Every pin source except over-temperature, with its enable picked at random
    foreach (tab[i]) begin
      p = tab[i] >> 8;
      b = tab[i] & 15;
      sa = tab[i][4] ? A_STB : A_STA;
      m = $urandom % 2;
      wr(tab[i][4] ? A_ENB : A_ENA, m << b);
      flip(16'(1 << p));
      tick(1200);
      flip(16'(1 << p));
      // Debounced sources need the full filter time to fall again
      tick(1200);
      chk(irq, m);
      rdc(sa, 1 << b);
      wr(sa, 0);
      rdc(sa, 1 << b);
      u_host_model.clear(sa, 1 << b);
      rdc(sa, 0);
      chk(irq, 0);
    end
    // Key release reporting and synchronised levels
    wr(A_CTL, 32'h18);
    for (int k = 0; k < 2; k++) begin
      sa = k ? A_STB : A_STA;
      b = k ? 1 : 5;
      flip(16'(1 << k));
      tick(8);
      rdc(A_LVL, 1 << k);
      u_host_model.clear(sa, 1 << b);
      flip(16'(1 << k));
      tick(8);
      rdc(A_LVL, 0);
      rdc(sa, 1 << b);
      u_host_model.clear(sa, 1 << b);
    end
    // Pulses shorter than the selected debounce are dropped
    wr(A_CTL, 32'h20);
    flip(16'h1020);
    tick(500);
    flip(16'h1020);
    tick(8);
    rdc(A_STA, 0);
    rdc(A_STB, 0);
    // Thermal rise then fall
    flip(16'h0004);
    tick(8);
    rdc(A_STA, 32'h80);
    u_host_model.clear(A_STA, 32'hc0);
    flip(16'h0004);
    tick(8);
    rdc(A_STA, 32'h40);
    u_host_model.clear(A_STA, 32'hc0);
    // Battery thresholds; mid value parks both flags quiet
    wr(A_BTH, 32'h10006000);
    bv <= 15'h6001 + 15'($urandom % 32'h1000);
    tick(6);
    bv <= 15'h3000;
    tick(6);
    rdc(A_STA, 32'h8);
    u_host_model.clear(A_STA, 32'hc);
    bv <= 15'($urandom % 32'h1000);
    tick(6);
    bv <= 15'h3000;
    tick(6);
    rdc(A_STA, 32'h4);
    u_host_model.clear(A_STA, 32'hc);
    // Watchdog at every gear: kick, then let it expire
    pin[3] <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      wr(A_CTL, 32'h1 | (g << 1));
      tick(6);
      chk(chg, 1);
      tick((BASE << g) / 2);
      u_host_model.kick();
      tick((BASE << g) - 20);
      chk(chg, 1);
      tick(30);
      chk(chg, 0);
      u_host_model.clear(A_STA, 32'hfff);
      rdc(A_STA, 32'h10);
      rdc(A_LVL, 32'(WD_TOUT) << 3);
      wr(A_CTL, 32'h0);
      u_host_model.clear(A_STA, 32'hfff);
      rdc(A_STA, 0);
    end
    wr(A_CTL, 32'h1);
    tick(6);
    chk(chg, 1);
    wr(A_CTL, 32'h0);
    tick(3);
    chk(chg, 0);
    wr(A_CTL, 32'h1);
    pin[3] <= 1'b0;
    tick(8);
    chk(chg, 0);
    results();
  end
endmodule
`default_nettype wire
